// ### logic/lcsr_pkg.sv
// lcsr_pkg: shared constants and types for the led current settings register
// assumes: one byte-wide register port, operating mode supplied by the control logic
package lcsr_pkg;
  localparam logic [7:0] LCSR_ADDR_SETTINGS = 8'h02;
  localparam logic [7:0] LCSR_ADDR_PASSWORD = 8'h80;
  localparam logic [7:0] LCSR_PASSWORD = 8'hA1;
  localparam logic [7:0] LCSR_RESET = 8'hB4;
  localparam logic [1:0] LCSR_SRC_LEVELS = 2'b00;
  localparam logic [1:0] LCSR_SRC_FINE = 2'b01;
  localparam logic [1:0] LCSR_SRC_LEVELS2 = 2'b10;
  localparam logic [1:0] LCSR_SRC_HIGH = 2'b11;
  localparam logic [1:0] LCSR_MODE_OFF = 2'b00;
  localparam logic [1:0] LCSR_MODE_IND = 2'b01;
  localparam logic [1:0] LCSR_MODE_ASSIST = 2'b10;
  localparam logic [1:0] LCSR_MODE_FLASH = 2'b11;
  // currents in microamps
  localparam logic [19:0] LCSR_FINE_STEP_UA = 20'd10000;
  localparam logic [19:0] LCSR_HIGH_STEP_UA = 20'd15625;
  localparam logic [19:0] LCSR_PSKIP_LIMIT_UA = 20'd320000;
  localparam logic [19:0] LCSR_ASSIST_LO_UA = 20'd51600;
  localparam logic [19:0] LCSR_ASSIST_HI_UA = 20'd72300;
  localparam logic [19:0] LCSR_FLASH_BASE_UA = 20'd260000;
  localparam logic [19:0] LCSR_FLASH_STEP_UA = 20'd20000;
  localparam logic [19:0] LCSR_IND_UA0 = 20'd1350;
  localparam logic [19:0] LCSR_IND_UA1 = 20'd2900;
  localparam logic [19:0] LCSR_IND_UA2 = 20'd4400;
  localparam logic [19:0] LCSR_IND_UA3 = 20'd6000;
  localparam int LCSR_PWM_PERIOD = 32;
  typedef struct packed {
    logic [1:0] flash_level;
    logic assist_level;
    logic [1:0] indicator_level;
    logic fixed_freq_enable;
    logic [1:0] led_source_select;
  } lcsr_fields_t;
  typedef struct packed {
    logic [19:0] current_ua;
    logic pulse_skip;
    logic pwm_on;
  } lcsr_drive_t;
endpackage

// ### logic/lcsr_pwm.sv
// lcsr_pwm: 32-slot duty generator for indicator light
// assumes: level from the same clock domain
`timescale 1ns/1ps
module lcsr_pwm
  import lcsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] level,
  output logic on
);
  logic [4:0] slot;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      slot <= 5'h0;
    else
      slot <= slot + 5'h1;
  end
  // duty (level+1)/32
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      on <= 1'b0;
    else
      on <= ({3'b000, level} >= slot);
  end
endmodule

// ### logic/lcsr_top.sv
// lcsr_top: led current settings register with password-guarded source select
// assumes: serial bus engine delivers decoded byte writes and reads on CLK
// How it works
// - select 10 takes current from indicator, assist and flash level fields
// - select 01 scales the five-bit code at 10mA per step
// - select 11 scales the five-bit code at 15.625mA per step to 500mA
// - five-bit code only in flash and assist modes with select 01 or 11
// - fixed frequency bit set disables pulse skip in flash and assist at currents up to 320mA
// - fixed frequency bit clear allows pulse skip in every mode
// - currents above 320mA always force pulse skip
// - indicator level selects pwm duty of one to four thirty-seconds
// - indicator average current 1.35, 2.9, 4.4 or 6.0mA
// - assist level selects 51.6mA or 72.3mA
// - flash level selects 260, 280, 300 or 320mA
`timescale 1ns/1ps
module lcsr_top
  import lcsr_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port from the serial engine
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // operating mode from the control register
  input wire logic [1:0] OP_MODE,
  // drive to the analog current source and boost
  output logic [19:0] LED_DRIVE_OUTPUT_UA,
  output logic LED_DRIVE_OUTPUT_ON,
  output logic PULSE_SKIP
);
  logic [7:0] settings;
  logic unlocked;
  logic pwm_on;
  lcsr_fields_t f;
  lcsr_drive_t next_drive;
  logic [19:0] fine_ua;
  logic sel_wr;
  logic pw_wr;

  assign f = lcsr_fields_t'(settings);
  assign sel_wr = WR_EN && (ADDR == LCSR_ADDR_SETTINGS);
  assign pw_wr = WR_EN && (ADDR == LCSR_ADDR_PASSWORD);

  // ----------------------------------------
  // password and register
  // ----------------------------------------
  // unlock lasts exactly until the next write of any kind
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      unlocked <= 1'b0;
    else if (WR_EN)
      unlocked <= pw_wr && (WDATA == LCSR_PASSWORD);
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      settings <= LCSR_RESET;
    else if (sel_wr)
    begin
      settings[7:2] <= WDATA[7:2];
      if (unlocked)
        settings[1:0] <= WDATA[1:0];
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      RDATA <= 8'h00;
    else if (RD_EN)
      RDATA <= (ADDR == LCSR_ADDR_SETTINGS) ? settings : 8'h00;
  end

  // ----------------------------------------
  // indicator pwm
  // ----------------------------------------
  lcsr_pwm u_pwm (
    .clk(CLK),
    .nrst(NRST),
    .level(f.indicator_level),
    .on(pwm_on)
  );

  // ----------------------------------------
  // current selection
  // ----------------------------------------
  always_comb
  begin
    fine_ua = 20'd0;
    next_drive = '0;
    if (f.led_source_select == LCSR_SRC_HIGH)
      fine_ua = 20'((20'({15'd0, settings[7:3]}) + 20'd1) * LCSR_HIGH_STEP_UA);
    else
      fine_ua = 20'((20'({15'd0, settings[7:3]}) + 20'd1) * LCSR_FINE_STEP_UA);
    unique case (OP_MODE)
      LCSR_MODE_OFF:
        next_drive.current_ua = 20'd0;
      LCSR_MODE_IND:
      begin
        next_drive.pwm_on = pwm_on;
        unique case (f.indicator_level)
          2'b00: next_drive.current_ua = LCSR_IND_UA0;
          2'b01: next_drive.current_ua = LCSR_IND_UA1;
          2'b10: next_drive.current_ua = LCSR_IND_UA2;
          2'b11: next_drive.current_ua = LCSR_IND_UA3;
        endcase
      end
      LCSR_MODE_ASSIST:
      begin
        next_drive.pwm_on = 1'b1;
        if (f.led_source_select[0])
          next_drive.current_ua = fine_ua;
        else
          next_drive.current_ua = f.assist_level ? LCSR_ASSIST_HI_UA : LCSR_ASSIST_LO_UA;
      end
      LCSR_MODE_FLASH:
      begin
        next_drive.pwm_on = 1'b1;
        if (f.led_source_select[0])
          next_drive.current_ua = fine_ua;
        else
          next_drive.current_ua = 20'(LCSR_FLASH_BASE_UA + 20'({18'd0, f.flash_level}) * LCSR_FLASH_STEP_UA);
      end
    endcase
    if (next_drive.current_ua > LCSR_PSKIP_LIMIT_UA)
      next_drive.pulse_skip = 1'b1;
    else if (OP_MODE == LCSR_MODE_ASSIST || OP_MODE == LCSR_MODE_FLASH)
      next_drive.pulse_skip = !f.fixed_freq_enable;
    else
      next_drive.pulse_skip = 1'b1;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      LED_DRIVE_OUTPUT_UA <= 20'd0;
      LED_DRIVE_OUTPUT_ON <= 1'b0;
      PULSE_SKIP <= 1'b1;
    end
    else
    begin
      LED_DRIVE_OUTPUT_UA <= next_drive.current_ua;
      LED_DRIVE_OUTPUT_ON <= next_drive.pwm_on;
      PULSE_SKIP <= next_drive.pulse_skip;
    end
  end

  // ----------------------------------------
  // checker helpers
  // ----------------------------------------
  // settle covers entry, the pwm register, the output register and a full 32-slot window
  localparam logic [5:0] IND_SETTLE = 6'h24;
  localparam logic [5:0] IND_RUN_MAX = 6'h3F;
  logic [5:0] ind_run;
  logic [31:0] on_hist;

  // saturates so a long indicator phase never wraps back below the settle mark
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      ind_run <= 6'h00;
    else if (sel_wr || OP_MODE != LCSR_MODE_IND)
      ind_run <= 6'h00;
    else if (ind_run != IND_RUN_MAX)
      ind_run <= ind_run + 6'h01;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      on_hist <= 32'h0000_0000;
    else
      on_hist <= {on_hist[30:0], LED_DRIVE_OUTPUT_ON};
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // unlock survives idle cycles, so the spaced pair must still take the select
  sequence pw_then_sel;
    (pw_wr && WDATA == LCSR_PASSWORD) ##1 !WR_EN ##1 sel_wr;
  endsequence

  select_unlock_a: assert property (@(posedge CLK) disable iff (!NRST)
    (sel_wr && !unlocked) |=> settings[1:0] == $past(settings[1:0]))
    else $error("select changed without password");
  select_update_a: assert property (@(posedge CLK) disable iff (!NRST)
    pw_then_sel |=> settings[1:0] == $past(WDATA[1:0]))
    else $error("select not taken after password");
  high_skip_a: assert property (@(posedge CLK) disable iff (!NRST)
    LED_DRIVE_OUTPUT_UA > LCSR_PSKIP_LIMIT_UA |-> PULSE_SKIP)
    else $error("pulse skip not forced");
  fixed_freq_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_FLASH && f.fixed_freq_enable && settings[1:0] == LCSR_SRC_LEVELS && $stable(settings)
     && $stable(OP_MODE)) |=> !PULSE_SKIP)
    else $error("fixed frequency not held");
  fine_range_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_ASSIST && settings[1:0] == LCSR_SRC_FINE && $stable(settings) && $stable(OP_MODE))
    |=> LED_DRIVE_OUTPUT_UA == 20'((20'({15'd0, $past(settings[7:3])}) + 20'd1) * LCSR_FINE_STEP_UA))
    else $error("fine current wrong");
  high_top_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_FLASH && settings[1:0] == LCSR_SRC_HIGH && &settings[7:3] && $stable(settings)
     && $stable(OP_MODE))
    |=> LED_DRIVE_OUTPUT_UA == 20'd500000)
    else $error("high range top wrong");
  flash_level_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_FLASH && settings[1:0] == LCSR_SRC_LEVELS2 && settings[7:6] == 2'b11
     && $stable(settings) && $stable(OP_MODE)) |=> LED_DRIVE_OUTPUT_UA == 20'd320000)
    else $error("flash level wrong");
  assist_level_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_ASSIST && settings[1:0] == LCSR_SRC_LEVELS && !settings[5]
     && $stable(settings) && $stable(OP_MODE)) |=> LED_DRIVE_OUTPUT_UA == 20'd51600)
    else $error("assist level wrong");
  off_dark_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_OFF) |=> !LED_DRIVE_OUTPUT_ON && LED_DRIVE_OUTPUT_UA == 20'd0)
    else $error("drive on while off");
  pwm_duty_a: assert property (@(posedge CLK) disable iff (!NRST)
    (ind_run >= IND_SETTLE) |-> $countones(on_hist) == int'(f.indicator_level) + 1)
    else $error("indicator duty wrong");
  ind_level_a: assert property (@(posedge CLK) disable iff (!NRST)
    (OP_MODE == LCSR_MODE_IND && $stable(settings) && $stable(OP_MODE))
    |=> LED_DRIVE_OUTPUT_UA == ($past(f.indicator_level) == 2'b11 ? LCSR_IND_UA3 :
      $past(f.indicator_level) == 2'b10 ? LCSR_IND_UA2 :
      $past(f.indicator_level) == 2'b01 ? LCSR_IND_UA1 : LCSR_IND_UA0))
    else $error("indicator current wrong");
endmodule

// ### verification/lcsr_host.sv
// lcsr_host: host side of the settings register port
// assumes: bench calls access and unlock, one byte per call
`timescale 1ns/1ps
module lcsr_host
  import lcsr_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // ----------------------------------------
  // single byte access
  // ----------------------------------------
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // released lines flip so a stale byte is never read as live
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic unlock();
    access(1'b1, LCSR_ADDR_PASSWORD, LCSR_PASSWORD);
  endtask
endmodule

// ### verification/test_led_current_setting_register.sv
// test_led_current_setting_register: self-checking bench for lcsr_top
// assumes: host model drives the register port, bench drives mode and reset
`timescale 1ns/1ps
module test_led_current_setting_register
  import lcsr_pkg::*;
;
  logic CLK, NRST, WR_EN, RD_EN, PULSE_SKIP, on, chk;
  logic rd_d = 1'b0;
  logic [1:0] OP_MODE;
  logic [7:0] ADDR, WDATA, RDATA, cur, d;
  logic [19:0] ua;
  logic [31:0] hist = 32'h0000_0000;
  logic [26:0] q_drv[$];
  logic [7:0] q_rd[$];
  int bad_count, checked;
  int cycles = 0;
  lcsr_host h (.clk(CLK), .wr_en(WR_EN), .rd_en(RD_EN), .addr(ADDR), .wdata(WDATA));
  lcsr_top i_dut (.CLK(CLK), .NRST(NRST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
    .RDATA(RDATA), .OP_MODE(OP_MODE), .LED_DRIVE_OUTPUT_UA(ua), .LED_DRIVE_OUTPUT_ON(on), .PULSE_SKIP(PULSE_SKIP));
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // ----------------------------------------
  // reference: current, skip flag, pwm on count in 32
  // ----------------------------------------
  function automatic logic [26:0] model(input logic [7:0] s, input logic [1:0] m);
    logic [19:0] e;
    logic ps;
    logic [5:0] n;
    e = 20'h0_0000;
    ps = 1'b1;
    n = 6'h20;
    if (m == LCSR_MODE_OFF)
      n = 6'h00;
    else if (m == LCSR_MODE_IND)
    begin
      e = s[4] ? (s[3] ? LCSR_IND_UA3 : LCSR_IND_UA2) : (s[3] ? LCSR_IND_UA1 : LCSR_IND_UA0);
      n = 6'(s[4:3]) + 6'h01;
    end
    else
    begin
      if (s[0])
        e = 20'((32'(s[7:3]) + 1) * 32'(s[1] ? LCSR_HIGH_STEP_UA : LCSR_FINE_STEP_UA));
      else if (m == LCSR_MODE_ASSIST)
        e = s[5] ? LCSR_ASSIST_HI_UA : LCSR_ASSIST_LO_UA;
      else
        e = LCSR_FLASH_BASE_UA + 20'(s[7:6]) * LCSR_FLASH_STEP_UA;
      ps = !s[2] || (e > LCSR_PSKIP_LIMIT_UA);
    end
    return {e, ps, n};
  endfunction
  // ----------------------------------------
  // drivers and compares
  // ----------------------------------------
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    h.access(1'b0, a, 8'h00);
  endtask
  task automatic chk_all();
    for (int m = 0; m < 4; m++)
    begin
      // indicator with fine code selected is left open, so skipped
      if (m != 1 || !cur[0])
      begin
        OP_MODE <= 2'(m);
        repeat (36) @(posedge CLK);
        q_drv.push_back(model(cur, 2'(m)));
        chk <= 1'b1;
        @(posedge CLK);
        chk <= 1'b0;
      end
    end
    OP_MODE <= LCSR_MODE_OFF;
    repeat (3) @(posedge CLK);
  endtask
  task automatic cmp_rd(input logic [7:0] e);
    checked++;
    if (RDATA !== e)
    begin
      bad_count++;
      $display("ERROR %0t read %h expected %h", $time, RDATA, e);
    end
  endtask
  task automatic cmp_drv(input logic [26:0] e);
    checked++;
    if ({ua, PULSE_SKIP, 6'($countones(hist))} !== e)
    begin
      bad_count++;
      $display("ERROR %0t drive %h %b expected %h", $time, ua, PULSE_SKIP, e);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  always @(posedge CLK)
  begin
    hist <= {hist[30:0], on};
    rd_d <= RD_EN;
    cycles <= cycles + 1;
    if (rd_d)
      cmp_rd(q_rd.pop_front());
    if (chk)
      cmp_drv(q_drv.pop_front());
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h8617));
    NRST = 1'b0;
    OP_MODE = LCSR_MODE_OFF;
    chk = 1'b0;
    bad_count = 0;
    checked = 0;
    cur = 8'hB4;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    rd_chk(LCSR_ADDR_SETTINGS, cur);
    chk_all();
    rd_chk(LCSR_ADDR_PASSWORD, 8'h00);
    // select change without fresh password, then with one spent elsewhere
    for (int j = 0; j < 2; j++)
    begin
      if (j == 1)
      begin
        h.unlock();
        h.access(1'b1, LCSR_ADDR_PASSWORD, 8'h00);
      end
      d = 8'($urandom) | 8'h03;
      h.access(1'b1, LCSR_ADDR_SETTINGS, d);
      cur = {d[7:2], cur[1:0]};
      rd_chk(LCSR_ADDR_SETTINGS, cur);
    end
    for (int i = 0; i < 14; i++)
    begin
      d = 8'($urandom);
      if (i < 4)
        d[1:0] = 2'(i);
      if (i == 4)
        d = 8'hFF;
      if (i == 5)
        d = 8'h7F;
      // top flash level on the level path, then low assist and lowest indicator
      if (i == 6)
        d = 8'hC6;
      if (i == 7)
        d = 8'h04;
      h.unlock();
      h.access(1'b1, LCSR_ADDR_SETTINGS, d);
      cur = d;
      rd_chk(LCSR_ADDR_SETTINGS, cur);
      chk_all();
    end
    // reset in mid-run restores defaults and drops a pending unlock
    h.unlock();
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    rd_chk(LCSR_ADDR_SETTINGS, 8'hB4);
    h.access(1'b1, LCSR_ADDR_SETTINGS, 8'hFF);
    cur = 8'hFC;
    rd_chk(LCSR_ADDR_SETTINGS, cur);
    chk_all();
    close_out();
  end
endmodule
